// ===== hw/rsx_exec.sv
// What this block does
// - rotate left through carry, msb to carry
// - rotate right, bit0 to bit7, flags kept
// - rotate right through carry, bit0 to carry
// - accumulator rotates leave memory untouched
// - acc minus mem minus inverted carry
// - borrow subtract may write memory instead
// - plain subtract to acc or memory
// - immediate subtract into accumulator
// - carry clear if negative, else set
// - decrement memory, skip when zero
// - decrement into acc, skip when zero
// - increment memory, skip on wrap
// - increment into acc, skip when zero
// - taken skip adds one dummy cycle
// - skip when selected bit is one
// - skip when selected bit is zero
// - skip when whole byte zero
// - load acc, skip when zero
// - set byte to ones or one bit
// - swap nibbles in place or to acc
// - table read in current page
// - table read in last page
module rsx_exec
    import rsx_pkg::*;
#(
    parameter int PROG_DEPTH = 2048,
    parameter int DATA_DEPTH = RAM_DEPTH
)
(
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic [CSR_AW-1:0]    avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic                 cmd_valid,
    input  rsx_pkg::rsx_cmd_type      cmd,
    output logic                      cmd_ready,
    output logic                      done,
    output logic                      skip_taken,
    output logic      [PC_W-1:0]      pc,
    input  wire logic                 prog_we,
    input  wire logic [PC_W-1:0]      prog_waddr,
    input  wire logic [PROG_W-1:0]    prog_wdata,
    input  wire logic                 mem_we,
    input  wire logic [RAM_AW-1:0]    mem_waddr,
    input  wire logic [DATA_W-1:0]    mem_wdata
);
    import rsx_pkg::*;

    typedef enum logic [1:0] { ST_IDLE, ST_EXEC, ST_TABLE, ST_DUMMY } rsx_state_type;

    rsx_state_type        state;
    rsx_cmd_type          cur;
    logic [DATA_W-1:0]    acc;
    logic [3:0]           flags;
    logic [DATA_W-1:0]    table_pointer;
    logic [DATA_W-1:0]    table_high_byte;
    logic [DATA_W-1:0]    data_mem [DATA_DEPTH];
    logic [DATA_W-1:0]    mem_val;
    logic [PROG_W-1:0]    prog_word;
    logic [PC_W-1:0]      table_addr;
    rsx_res_type          alu_res;
    logic                 bus_hit;
    logic                 csr_we;
    logic                 core_mem_we;
    logic [DATA_W-1:0]    core_mem_data;

    function automatic logic [PC_W-1:0] table_address(input logic last, input logic [PC_W-1:0] cur_pc,
                                                       input logic [DATA_W-1:0] ptr);
        logic [PC_W-1:0] base;
        base = last ? LAST_PAGE : (cur_pc & PAGE_MASK);
        return base | {3'b000, ptr};
    endfunction : table_address

    assign mem_val = data_mem[cur.addr];

    rsx_alu u_alu (
        .cmd      (cur),
        .mem_val  (mem_val),
        .acc_val  (acc),
        .flags_in (flags),
        .res      (alu_res)
    );

    assign table_addr = table_address(cur.op == OP_TABLE_LAST, pc, table_pointer);

    rsx_prog_rom #(.DEPTH(PROG_DEPTH)) u_rom (
        .mclk  (mclk),
        .rst_n (rst_n),
        .we    (prog_we),
        .waddr (prog_waddr),
        .wdata (prog_wdata),
        .raddr (table_addr),
        .rdata (prog_word)
    );

    // sequencer: an accept cycle then one execute cycle per instruction, table read waits for the rom, skip adds a dummy
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state     <= ST_IDLE;
            cur       <= '0;
            cmd_ready <= 1'b1;
            done      <= 1'b0;
            skip_taken <= 1'b0;
        end
        else
        begin
            done       <= 1'b0;
            skip_taken <= 1'b0;
            case (state)
                ST_IDLE:
                    if (cmd_valid)
                    begin
                        cur       <= cmd;
                        cmd_ready <= 1'b0;
                        state     <= (cmd.op == OP_TABLE_CUR || cmd.op == OP_TABLE_LAST) ? ST_TABLE : ST_EXEC;
                    end
                ST_TABLE:
                    state <= ST_EXEC;
                ST_EXEC:
                    if (alu_res.skip)
                    begin
                        state      <= ST_DUMMY;
                        skip_taken <= 1'b1;
                    end
                    else
                    begin
                        state     <= ST_IDLE;
                        done      <= 1'b1;
                        cmd_ready <= 1'b1;
                    end
                ST_DUMMY:
                begin
                    state     <= ST_IDLE;
                    done      <= 1'b1;
                    cmd_ready <= 1'b1;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // program counter advances by one, or by two when a skip was taken
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pc <= PC_RST;
        else if (state == ST_EXEC && !alu_res.skip)
            pc <= pc + PC_ONE;
        else if (state == ST_DUMMY)
            pc <= pc + PC_TWO;
    end

    always_comb
    begin
        core_mem_we   = 1'b0;
        core_mem_data = alu_res.res;
        if (state == ST_EXEC)
        begin
            if (cur.op == OP_TABLE_CUR || cur.op == OP_TABLE_LAST)
            begin
                core_mem_we   = 1'b1;
                core_mem_data = prog_word[DATA_W-1:0];
            end
            else
                core_mem_we = alu_res.to_mem;
        end
    end

    // core write has priority over the preload port
    always_ff @(posedge mclk)
    begin
        if (core_mem_we)
            data_mem[cur.addr] <= core_mem_data;
        else if (mem_we)
            data_mem[mem_waddr] <= mem_wdata;
    end

    assign bus_hit = avs_write && avs_waitrequest == 1'b0;
    assign csr_we  = bus_hit && state == ST_IDLE;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            acc <= BYTE_ZERO;
        else if (state == ST_EXEC && alu_res.to_acc)
            acc <= alu_res.res;
        else if (csr_we && avs_address == OFS_ACC)
            acc <= avs_writedata[DATA_W-1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            flags <= FLAG_RST;
        else if (state == ST_EXEC)
            flags <= (alu_res.flags & alu_res.flag_we) | (flags & ~alu_res.flag_we);
        else if (csr_we && avs_address == OFS_STATUS)
            flags <= avs_writedata[3:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            table_pointer <= BYTE_ZERO;
        else if (csr_we && avs_address == OFS_CTRL)
            table_pointer <= avs_writedata[DATA_W-1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            table_high_byte <= BYTE_ZERO;
        else if (state == ST_EXEC && (cur.op == OP_TABLE_CUR || cur.op == OP_TABLE_LAST))
            table_high_byte <= {2'b00, prog_word[PROG_W-1:DATA_W]};
    end

    // avalon slave: every access answers in the cycle after it is raised
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end
        else
        begin
            avs_waitrequest <= 1'b1;
            if ((avs_read || avs_write) && avs_waitrequest)
            begin
                avs_waitrequest <= 1'b0;
                avs_readdata    <= '0;
                case (avs_address)
                    OFS_CTRL:   avs_readdata[DATA_W-1:0] <= table_pointer;
                    OFS_ACC:    avs_readdata[DATA_W-1:0] <= acc;
                    OFS_STATUS:
                    begin
                        avs_readdata[3:0]      <= flags;
                        avs_readdata[BUSY_BIT] <= (state != ST_IDLE);
                        avs_readdata[SKIP_BIT] <= (state == ST_DUMMY);
                    end
                    OFS_TABLE:  avs_readdata[DATA_W-1:0] <= table_high_byte;
                    default:    avs_readdata <= '0;
                endcase
            end
        end
    end

endmodule : rsx_exec

// ===== pkg/rsx_pkg.sv
package rsx_pkg;

    localparam int DATA_W   = 8;
    localparam int PROG_W   = 14;
    localparam int PC_W     = 11;
    localparam int RAM_AW   = 7;
    localparam int RAM_DEPTH = 96;
    localparam int CSR_AW   = 4;

    // register offsets (byte addresses on the bus)
    localparam logic [CSR_AW-1:0] OFS_CTRL   = 4'h0;
    localparam logic [CSR_AW-1:0] OFS_ACC    = 4'h4;
    localparam logic [CSR_AW-1:0] OFS_STATUS = 4'h8;
    localparam logic [CSR_AW-1:0] OFS_TABLE  = 4'hc;

    // flag bit positions in the status register
    localparam int FLAG_C  = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_OV = 3;
    localparam int BUSY_BIT = 8;
    localparam int SKIP_BIT = 9;

    localparam logic [DATA_W-1:0] BYTE_ONES = 8'hff;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE  = 8'h01;
    localparam logic [3:0]        FLAG_RST  = 4'h0;
    localparam logic [PC_W-1:0]   PC_RST    = 11'h000;
    localparam logic [PC_W-1:0]   PC_ONE    = 11'h001;
    localparam logic [PC_W-1:0]   PC_TWO    = 11'h002;
    localparam logic [PC_W-1:0]   PAGE_MASK = 11'h700;
    localparam logic [PC_W-1:0]   LAST_PAGE = 11'h700;

    typedef enum logic [4:0] {
        OP_NOP, OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SBC, OP_SUB, OP_SUB_IMM,
        OP_DEC_SKIP, OP_INC_SKIP, OP_SKIP_BIT_SET, OP_SKIP_BIT_CLR, OP_SKIP_ZERO,
        OP_LOAD_SKIP, OP_SET_BYTE, OP_SET_BIT, OP_SWAP, OP_TABLE_CUR, OP_TABLE_LAST,
        OP_XOR, OP_XOR_IMM
    } rsx_op_type;

    typedef struct packed {
        rsx_op_type         op;
        logic               to_acc;
        logic [RAM_AW-1:0]  addr;
        logic [2:0]         bit_sel;
        logic [DATA_W-1:0]  imm;
    } rsx_cmd_type;

    typedef struct packed {
        logic [DATA_W-1:0] res;
        logic [3:0]        flags;
        logic [3:0]        flag_we;
        logic              to_acc;
        logic              to_mem;
        logic              skip;
    } rsx_res_type;

endpackage : rsx_pkg

// ===== hw/rsx_alu.sv
module rsx_alu
    import rsx_pkg::*;
(
    input  rsx_pkg::rsx_cmd_type       cmd,
    input  wire logic [7:0]            mem_val,
    input  wire logic [7:0]            acc_val,
    input  wire logic [3:0]            flags_in,
    output rsx_pkg::rsx_res_type       res
);
    import rsx_pkg::*;

    function automatic logic [11:0] sub_core(input logic [7:0] a, input logic [7:0] b, input logic bin);
        logic [8:0] full;
        logic [4:0] low;
        logic       ov;
        full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
        low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
        ov   = (a[7] ^ b[7]) & (a[7] ^ full[7]);
        // carry set means no borrow: result zero or positive
        return {full[7:0], ov, (full[7:0] == BYTE_ZERO), ~low[4], ~full[8]};
    endfunction : sub_core

    logic [11:0] diff;
    logic [7:0]  bval;
    logic        cin;

    always_comb
    begin
        cin  = flags_in[FLAG_C];
        bval = (cmd.op == OP_SUB_IMM) ? cmd.imm : mem_val;
        diff = sub_core(acc_val, bval, (cmd.op == OP_SBC) ? ~cin : 1'b0);
        res         = '0;
        res.flags   = flags_in;
        res.to_acc  = cmd.to_acc;
        res.to_mem  = ~cmd.to_acc;
        case (cmd.op)
            OP_RL:
                res.res = {mem_val[6:0], mem_val[7]};
            OP_RLC:
            begin
                res.res = {mem_val[6:0], cin};
                res.flags[FLAG_C] = mem_val[7];
                res.flag_we[FLAG_C] = 1'b1;
            end
            OP_RR:
                res.res = {mem_val[0], mem_val[7:1]};
            OP_RRC:
            begin
                res.res = {cin, mem_val[7:1]};
                res.flags[FLAG_C] = mem_val[0];
                res.flag_we[FLAG_C] = 1'b1;
            end
            OP_SBC, OP_SUB, OP_SUB_IMM:
            begin
                res.res = diff[11:4];
                res.flags[FLAG_C] = diff[0];
                res.flags[FLAG_AC] = diff[1];
                res.flags[FLAG_Z] = diff[2];
                res.flags[FLAG_OV] = diff[3];
                res.flag_we = 4'hf;
                if (cmd.op == OP_SUB_IMM)
                begin
                    res.to_acc = 1'b1;
                    res.to_mem = 1'b0;
                end
            end
            OP_DEC_SKIP:
            begin
                res.res  = mem_val - BYTE_ONE;
                res.skip = (res.res == BYTE_ZERO);
            end
            OP_INC_SKIP:
            begin
                res.res  = mem_val + BYTE_ONE;
                res.skip = (res.res == BYTE_ZERO);
            end
            OP_SKIP_BIT_SET:
            begin
                res.to_mem = 1'b0;
                res.to_acc = 1'b0;
                res.skip   = mem_val[cmd.bit_sel];
            end
            OP_SKIP_BIT_CLR:
            begin
                res.to_mem = 1'b0;
                res.to_acc = 1'b0;
                res.skip   = ~mem_val[cmd.bit_sel];
            end
            OP_SKIP_ZERO:
            begin
                res.to_mem = 1'b0;
                res.to_acc = 1'b0;
                res.skip   = (mem_val == BYTE_ZERO);
            end
            OP_LOAD_SKIP:
            begin
                res.res    = mem_val;
                res.to_acc = 1'b1;
                res.to_mem = 1'b0;
                res.skip   = (mem_val == BYTE_ZERO);
            end
            OP_SET_BYTE:
            begin
                res.res    = BYTE_ONES;
                res.to_acc = 1'b0;
                res.to_mem = 1'b1;
            end
            OP_SET_BIT:
            begin
                res.res = mem_val;
                res.res[cmd.bit_sel] = 1'b1;
                res.to_acc = 1'b0;
                res.to_mem = 1'b1;
            end
            OP_SWAP:
                res.res = {mem_val[3:0], mem_val[7:4]};
            OP_XOR, OP_XOR_IMM:
            begin
                res.res = acc_val ^ ((cmd.op == OP_XOR_IMM) ? cmd.imm : mem_val);
                res.flags[FLAG_Z] = (res.res == BYTE_ZERO);
                res.flag_we[FLAG_Z] = 1'b1;
                if (cmd.op == OP_XOR_IMM)
                begin
                    res.to_acc = 1'b1;
                    res.to_mem = 1'b0;
                end
            end
            default:
            begin
                // table reads and nop handled by the sequencer
                res.to_acc = 1'b0;
                res.to_mem = 1'b0;
            end
        endcase
    end

endmodule : rsx_alu

// ===== hw/rsx_prog_rom.sv
module rsx_prog_rom
    import rsx_pkg::*;
#(
    parameter int DEPTH = 2048
)
(
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 we,
    input  wire logic [PC_W-1:0]      waddr,
    input  wire logic [PROG_W-1:0]    wdata,
    input  wire logic [PC_W-1:0]      raddr,
    output logic      [PROG_W-1:0]    rdata
);
    import rsx_pkg::*;

    // loadable store stands in for the mask rom; one cycle read latency
    logic [PROG_W-1:0] words [DEPTH];

    always_ff @(posedge mclk)
    begin
        if (we)
            words[waddr] <= wdata;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rdata <= '0;
        else
            rdata <= words[raddr];
    end

endmodule : rsx_prog_rom

// ===== verif/rsx_exec_checker.sv
module rsx_exec_checker
    import rsx_pkg::*;
(
    input wire logic          mclk,
    input wire logic          rst_n,
    input wire logic          avs_read,
    input wire logic          avs_write,
    input wire logic          avs_waitrequest,
    input wire logic          cmd_valid,
    input rsx_pkg::rsx_cmd_type cmd,
    input wire logic          cmd_ready,
    input wire logic          done,
    input wire logic          skip_taken,
    input wire logic [PC_W-1:0] pc
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    wire logic take = cmd_valid && cmd_ready;
    wire logic tbl  = cmd.op == OP_TABLE_CUR || cmd.op == OP_TABLE_LAST;

    property p_ans;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_ans: assert property (p_ans) else $error("bus request not answered in one cycle");
    property p_ws1;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_ws1: assert property (p_ws1) else $error("waitrequest low longer than one cycle");
    property p_take;
        take |=> !cmd_ready;
    endproperty
    a_take: assert property (p_take) else $error("ready stayed high after a command was taken");
    property p_end;
        take && !tbl |-> ##2 (done || skip_taken);
    endproperty
    a_end: assert property (p_end) else $error("instruction did not end or skip on time");
    property p_tbl;
        take && tbl |-> ##3 done;
    endproperty
    a_tbl: assert property (p_tbl) else $error("table read did not end on time");
    property p_skip;
        skip_taken |=> done && !skip_taken;
    endproperty
    a_skip: assert property (p_skip) else $error("skip without one dummy cycle");
    property p_pulse;
        done |=> !done;
    endproperty
    a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
    property p_rdy;
        $rose(cmd_ready) |-> done;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready returned without done");
    property p_idle;
        (cmd_ready && !cmd_valid && !done) [*2] |=> $stable(pc);
    endproperty
    a_idle: assert property (p_idle) else $error("pc moved while idle");
    property p_busy;
        skip_taken |-> !cmd_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready during dummy cycle");

    c_skip: cover property (skip_taken);
    c_plain: cover property (done && !$past(skip_taken));
    c_tbl: cover property (take && tbl);
    c_bus: cover property (avs_read && !avs_waitrequest);
endmodule : rsx_exec_checker

bind rsx_exec rsx_exec_checker u_chk (.mclk, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
    .cmd_valid, .cmd, .cmd_ready, .done, .skip_taken, .pc);

// ===== verif/rsx_mem_model.sv
module rsx_mem_model
    import rsx_pkg::*;
(
    input  wire logic             mclk,
    output logic                  prog_we,
    output logic [PC_W-1:0]       prog_waddr,
    output logic [PROG_W-1:0]     prog_wdata,
    output logic                  mem_we,
    output logic [RAM_AW-1:0]     mem_waddr,
    output logic [DATA_W-1:0]     mem_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        prog_we = 0; prog_waddr = '0; prog_wdata = '0;
        mem_we = 0; mem_waddr = '0; mem_wdata = '0;
    end
    // released data lines show the inverse so stale values cannot pass
    task load_prog(input logic [PC_W-1:0] a, input logic [PROG_W-1:0] d);
        @(posedge mclk);
        prog_we <= 1; prog_waddr <= a; prog_wdata <= d;
        @(posedge mclk);
        prog_we <= 0; prog_wdata <= ~d;
    endtask : load_prog
    task load_byte(input logic [RAM_AW-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        mem_we <= 1; mem_waddr <= a; mem_wdata <= d;
        @(posedge mclk);
        mem_we <= 0; mem_wdata <= ~d;
    endtask : load_byte
endmodule : rsx_mem_model

// ===== verif/rsx_exec_bench.sv
module rsx_exec_bench
    import rsx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] a; logic [7:0] m; logic [3:0] f; logic s;} rsx_exp_type;
    logic mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0, cmd_valid = 0, avs_waitrequest, cmd_ready;
    logic done, skip_taken, prog_we, mem_we;
    logic [CSR_AW-1:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, rd;
    rsx_cmd_type cmd = '0, c;
    logic [PC_W-1:0] pc, prog_waddr, exp_pc = '0;
    logic [PROG_W-1:0] prog_wdata, w;
    logic [RAM_AW-1:0] mem_waddr;
    logic [DATA_W-1:0] mem_wdata, m, a, p;
    logic [3:0] f;
    logic sk;
    rsx_exp_type e;
    int error_cnt = 0, n_checks = 0;
    logic [31:0] seed = 32'h7fc016ce;
    rsx_op_type ops [18] = '{OP_RLC, OP_RR, OP_RRC, OP_SBC, OP_SUB, OP_SUB_IMM, OP_DEC_SKIP, OP_INC_SKIP,
        OP_SKIP_BIT_SET, OP_SKIP_BIT_CLR, OP_SKIP_ZERO, OP_LOAD_SKIP, OP_SET_BYTE, OP_SET_BIT, OP_SWAP, OP_XOR,
        OP_RL, OP_XOR_IMM};
    logic [7:0] corner [4] = '{8'h00, 8'h01, 8'hff, 8'h80};

    always #2 mclk = ~mclk;

    rsx_exec dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .done(done), .skip_taken(skip_taken), .pc(pc), .prog_we(prog_we), .prog_waddr(prog_waddr),
        .prog_wdata(prog_wdata), .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata));
    rsx_mem_model u_mem (.mclk(mclk), .prog_we(prog_we), .prog_waddr(prog_waddr), .prog_wdata(prog_wdata),
        .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic rsx_exp_type model(rsx_cmd_type c, logic [7:0] m, logic [7:0] a, logic [3:0] f);
        rsx_exp_type e;
        logic [7:0] b, r;
        logic bi;
        logic [8:0] d;
        logic [4:0] h;
        e = '{a: a, m: m, f: f, s: 1'b0};
        b = (c.op inside {OP_SUB_IMM, OP_XOR_IMM}) ? c.imm : m;
        bi = (c.op == OP_SBC) ? ~f[FLAG_C] : 1'b0;
        d = {1'b0, a} - {1'b0, b} - bi;
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - bi;
        r = d[7:0];
        case (c.op)
            OP_RLC: {e.f[FLAG_C], r} = {m, f[FLAG_C]};
            OP_RL: r = {m[6:0], m[7]};
            OP_RR: r = {m[0], m[7:1]};
            OP_RRC: {r, e.f[FLAG_C]} = {f[FLAG_C], m};
            OP_SBC, OP_SUB, OP_SUB_IMM: e.f = {(a[7] != b[7]) && (r[7] != a[7]), r == 0, ~h[4], ~d[8]};
            OP_DEC_SKIP: begin r = m - 1; e.s = r == 0; end
            OP_INC_SKIP: begin r = m + 1; e.s = r == 0; end
            OP_SKIP_BIT_SET: e.s = m[c.bit_sel];
            OP_SKIP_BIT_CLR: e.s = !m[c.bit_sel];
            OP_SKIP_ZERO: e.s = m == 0;
            OP_LOAD_SKIP: begin e.a = m; e.s = m == 0; end
            OP_SET_BYTE: e.m = BYTE_ONES;
            OP_SET_BIT: e.m = m | (8'h01 << c.bit_sel);
            OP_SWAP: r = {m[3:0], m[7:4]};
            default: begin r = a ^ b; e.f[FLAG_Z] = r == 0; end
        endcase
        if (c.op inside {OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SBC, OP_SUB, OP_DEC_SKIP, OP_INC_SKIP, OP_SWAP, OP_XOR})
            if (c.to_acc) e.a = r; else e.m = r;
        if (c.op inside {OP_SUB_IMM, OP_XOR_IMM}) e.a = r;
        return e;
    endfunction : model

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
        int k;
        avs_address <= ad; avs_writedata <= wd; avs_write <= wr; avs_read <= !wr;
        k = 0;
        do begin @(posedge mclk); k++; end while (avs_waitrequest !== 1'b0 && k < 20);
        rd = avs_readdata;
        if (k >= 20) chk(k, 0);
        avs_read <= 0; avs_write <= 0;
        @(posedge mclk);
    endtask : bus

    // ends one cycle after done so pc has surely settled
    task exec(input rsx_cmd_type c, input logic ex_s);
        int k;
        cmd <= c; cmd_valid <= 1; k = 0;
        do begin @(posedge mclk); k++; end while (cmd_ready !== 1'b1 && k < 20);
        if (k >= 20) chk(k, 0);
        cmd_valid <= 0; sk = 0; k = 0;
        do begin @(posedge mclk); k++; if (skip_taken === 1'b1) sk = 1; end while (done !== 1'b1 && k < 12);
        if (k >= 12) chk(k, 0);
        @(posedge mclk);
        exp_pc = exp_pc + (ex_s ? PC_TWO : PC_ONE);
        chk(sk, ex_s);
        chk(pc, exp_pc);
    endtask : exec

    // memory is only visible by copying it into the accumulator
    task mem_chk(input logic [RAM_AW-1:0] ad, input logic [7:0] ex);
        c = '0; c.op = OP_LOAD_SKIP; c.addr = ad;
        exec(c, ex == 0);
        bus(0, OFS_ACC, 0);
        chk(rd[7:0], ex);
    endtask : mem_chk

    task report_and_stop();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        #100000;
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        repeat (4) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        foreach (corner[i]) begin bus(0, 4'(i * 4), 0); chk(rd, 0); end
        bus(0, 4'h2, 0);
        chk(rd, 0);
        // every op meets every corner byte once, in alternate sweeps of the op list
        for (int i = 0; i < 144; i++)
        begin
            c = '0; c.op = ops[i % 18]; c.to_acc = 1'(rnd()); c.addr = RAM_AW'(rnd() % RAM_DEPTH);
            c.bit_sel = 3'(rnd()); c.imm = 8'(rnd());
            m = ((i / 18) % 2 == 0) ? corner[(i / 36) % 4] : 8'(rnd()); a = 8'(rnd()); f = 4'(rnd());
            u_mem.load_byte(c.addr, m);
            bus(1, OFS_ACC, {24'h0, a});
            bus(1, OFS_STATUS, {28'h0, f});
            e = model(c, m, a, f);
            exec(c, e.s);
            bus(0, OFS_ACC, 0);
            chk(rd[7:0], e.a);
            bus(0, OFS_STATUS, 0);
            chk(rd[3:0], e.f);
            mem_chk(c.addr, e.m);
        end
        for (int j = 0; j < 2; j++)
        begin
            p = 8'(rnd()); w = PROG_W'(rnd()); c = '0; c.addr = RAM_AW'(rnd() % RAM_DEPTH);
            c.op = j ? OP_TABLE_LAST : OP_TABLE_CUR;
            u_mem.load_prog({exp_pc[10:8], p}, w ^ {PROG_W{j[0]}});
            u_mem.load_prog(LAST_PAGE | p, ~w ^ {PROG_W{j[0]}});
            bus(1, OFS_CTRL, {24'h0, p});
            exec(c, 1'b0);
            bus(0, OFS_TABLE, 0);
            chk(rd[7:0], {2'b00, w[13:8]});
            mem_chk(c.addr, w[7:0]);
        end
        report_and_stop();
    end
endmodule : rsx_exec_bench
